// ==== design/fds_cfg.svh ====
// Constants for the fan duty and standby sequencer
//
// Function
// - Count running hours separately per fan, only while that fan runs.
// - On first start, start the fan with the fewest hours.
// - Stopping or failure of a fan rotates the duty role to the other fan.
// - A running fan that fails raises a fault event and starts the standby.
// - No airflow within 10 s: stop fan, start standby, raise flow alarm.
// - Flow alarm is suppressed while the fan runs under emergency.
// - Open the damper first; start the fan only when all sections are open.
// - Fan not running within proving period: stop, close damper, alarm, rotate.
// - Damper not open within set timeout: drop open, close, drop start, alarm.
// - Emergency drives damper and fan together and ignores protective trips.
// - First stage starts fewest-hours fan; second stage starts the second fan.
// - Falling temperature stops most-hours fan first, then the other, with hysteresis.
// - Manual disables staging for that fan but stage alarms still report.
// - Selector in remote ignores local panel inputs.
// - Local normal: automatics off, stage alarms kept, local commands, interlocks on.
// - Local emergency bypasses trips but still reports protective alarms.
// - Maintenance switch keeps the fan disabled against every normal command.
// - Any emergency mode overrides all normal command paths.
// - A selected scenario is fully established within 3 minutes.
// - Equipment failure in an active scenario raises alarm; scenario continues.
// - Panel scenario pushbuttons start the scenario; adjacent-shaft action goes to network.
// - Priority: panel scenario, local emergency, station workstation, central workstation.
// - Panel scenario cancels workstation scenarios and blocks new selections.
// - Auto to manual keeps the current run state until a manual command.
`ifndef FDS_CFG_SVH
`define FDS_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FDS_CLK_HZ        125000000
`define FDS_TICK_S        1
`define FDS_FLOW_S        10
`define FDS_PROVE_S       5
`define FDS_SCEN_S        180
`define FDS_SEC_PER_HOUR  3600
`define FDS_DMP_TO_RST    8'h1E

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FDS_OFF_CTRL      8'h00
`define FDS_OFF_CMD       8'h04
`define FDS_OFF_DMPTO     8'h08
`define FDS_OFF_SETPT     8'h0C
`define FDS_OFF_HYST      8'h10
`define FDS_OFF_STATUS    8'h14
`define FDS_OFF_ALARM     8'h18
`define FDS_OFF_HOURS0    8'h1C
`define FDS_OFF_HOURS1    8'h20

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FDS_CTRL_AUTO     0
`define FDS_CTRL_STN      4
`define FDS_CTRL_CEN      6
`define FDS_CMD_START     0
`define FDS_CMD_STOP      2
`define FDS_CMD_UNLOCK    4
`define FDS_CTRL_RST      8'h03
`define FDS_SETPT_RST     24'h1E0190
`define FDS_HYST_RST      12'h010

`endif

// ==== design/fds_pkg.sv ====
// Types for the fan duty and standby sequencer
package fds_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_OPEN, ST_PROVE, ST_RUN, ST_EMRG} fds_fan_state_type;

  typedef enum logic [1:0] {LOC_REMOTE, LOC_NORMAL, LOC_EMERG} fds_local_sel_type;

  typedef struct packed {
    logic       running;
    logic       flowOk;
    logic [1:0] damperOpen;
    logic       fault;
    logic       trip;
    logic       maint;
  } fds_fan_in_type;

  typedef struct packed {
    logic start;
    logic reverse;
    logic damperOpen;
    logic damperClose;
  } fds_fan_out_type;

endpackage

// ==== design/fds_sequencer.sv ====
// Duty and standby sequencer for a fan pair with dampers, modes and APB registers
`timescale 1ns/1ps
`include "fds_cfg.svh"

module fds_sequencer
  import fds_pkg::*;
#(
  parameter int TICK_CYCLES = `FDS_CLK_HZ * `FDS_TICK_S
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // APB slave
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Field sensors and temperature
  input  wire fds_fan_in_type [1:0]    fanIn,
  input  wire logic [11:0]             tempIn,
  // Local switchboard and emergency panel
  input  wire fds_local_sel_type       localSel,
  input  wire logic [1:0]              localStartPb,
  input  wire logic [1:0]              localStopPb,
  input  wire logic                    panelScenarioSel,
  input  wire logic [1:0]              panelScenarioPb,
  // Field commands and events
  output fds_fan_out_type [1:0]        fanOut,
  output logic [1:0]                   faultEvent,
  output logic                         alarmOut,
  output logic [1:0]                   netScenario
);

  // ----------------------------------------
  // Derived counts
  // ----------------------------------------
  localparam logic [7:0]  FLOW_TICKS  = 8'(`FDS_FLOW_S / `FDS_TICK_S);
  localparam logic [7:0]  PROVE_TICKS = 8'(`FDS_PROVE_S / `FDS_TICK_S);
  localparam logic [7:0]  SCEN_TICKS  = 8'(`FDS_SCEN_S / `FDS_TICK_S);
  localparam logic [11:0] HOUR_TICKS  = 12'(`FDS_SEC_PER_HOUR / `FDS_TICK_S);

  // Scenario pattern: {reverse[1:0], run[1:0]}
  function automatic logic [3:0] scenPattern(input logic [1:0] code);
    case (code)
      2'h1:    scenPattern = 4'h3;
      2'h2:    scenPattern = 4'hF;
      2'h3:    scenPattern = 4'h1;
      default: scenPattern = 4'h0;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  fds_fan_state_type st_reg [2];
  fds_fan_state_type st_next [2];
  logic [7:0]  cnt_reg [2];
  logic [7:0]  cnt_next [2];
  logic [11:0] secCnt_reg [2];
  logic [19:0] hours_reg [2];
  logic [1:0]  flowOk_reg, flowOk_next;
  logic [1:0]  locked_reg, locked_next;
  logic [1:0]  manRun_reg, locRun_reg;
  logic [1:0]  stage_reg, stage_next;
  logic        duty_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  dmpTo_reg;
  logic [23:0] setpt_reg;
  logic [11:0] hyst_reg;
  logic [12:0] alarm_reg;
  logic [12:0] alarmSet;
  logic [7:0]  scenCnt_reg;
  logic [1:0]  scenCode_reg;
  logic [26:0] tickCnt_reg;
  logic        tick_reg;
  logic [1:0]  rotEvt, failEvt, stbyEvt;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg, alarmOut_reg;
  logic [1:0]  faultEvent_reg, netScenario_reg;
  fds_fan_out_type [1:0] fanOut_reg;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setupPh  = psel & ~penable;
  wire accessWr = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  wire hitCtrl  = paddr == `FDS_OFF_CTRL;
  wire hitCmd   = paddr == `FDS_OFF_CMD;
  wire hitDmp   = paddr == `FDS_OFF_DMPTO;
  wire hitSet   = paddr == `FDS_OFF_SETPT;
  wire hitHyst  = paddr == `FDS_OFF_HYST;
  wire hitStat  = paddr == `FDS_OFF_STATUS;
  wire hitAlarm = paddr == `FDS_OFF_ALARM;
  wire hitHrs0  = paddr == `FDS_OFF_HOURS0;
  wire hitHrs1  = paddr == `FDS_OFF_HOURS1;
  wire addrHit  = hitCtrl | hitCmd | hitDmp | hitSet | hitHyst | hitStat | hitAlarm | hitHrs0 | hitHrs1;
  wire wrCtrl   = accessWr & hitCtrl;
  wire wrCmd    = accessWr & hitCmd;
  wire [1:0] cmdStart = wrCmd ? pwdata[`FDS_CMD_START +: 2] : 2'h0;
  wire [1:0] cmdStop  = wrCmd ? pwdata[`FDS_CMD_STOP +: 2] : 2'h0;
  wire       cmdUnlock = wrCmd & pwdata[`FDS_CMD_UNLOCK];
  wire [12:0] alarmClr = (accessWr & hitAlarm) ? pwdata[12:0] : 13'h0000;

  // ----------------------------------------
  // Mode arbitration
  // ----------------------------------------
  wire [1:0]  autoMode  = ctrl_reg[`FDS_CTRL_AUTO +: 2];
  wire [1:0]  stnCode   = ctrl_reg[`FDS_CTRL_STN +: 2];
  wire [1:0]  cenCode   = ctrl_reg[`FDS_CTRL_CEN +: 2];
  wire [1:0]  maint     = {fanIn[1].maint, fanIn[0].maint};
  wire        panelAct  = panelScenarioSel & (panelScenarioPb != 2'h0);
  wire        locEmerg  = localSel == LOC_EMERG;
  wire [1:0]  wsCode    = (stnCode != 2'h0) ? stnCode : cenCode;
  wire        wsAct     = wsCode != 2'h0;
  wire [1:0]  scenCode  = panelAct ? panelScenarioPb : wsCode;
  wire [3:0]  pattern   = scenPattern(scenCode);
  wire        emerg     = panelAct | locEmerg | wsAct;
  wire [1:0]  emWant    = (locEmerg & ~panelAct) ? locRun_reg : pattern[1:0];
  wire [1:0]  emRev     = (locEmerg & ~panelAct) ? 2'h0 : pattern[3:2];
  wire [1:0]  avail     = ~maint & ~locked_reg;
  wire        lowHrs    = hours_reg[1] < hours_reg[0];
  wire        lead      = avail[duty_reg] ? duty_reg : ~duty_reg;
  wire [1:0]  leadMask  = lead ? 2'h2 : 2'h1;
  // stage one lead, stage two both
  wire [1:0]  autoWant  = (stage_reg == 2'h2) ? 2'h3 : ((stage_reg == 2'h1) ? leadMask : 2'h0);
  wire [1:0]  remWant   = (autoMode & autoWant) | (~autoMode & manRun_reg);
  wire [1:0]  normWant  = (localSel == LOC_NORMAL) ? locRun_reg : remWant;
  wire [1:0]  want      = emerg ? (emWant & ~maint) : (normWant & avail);
  wire        scenDone  = ((st_reg[0] == ST_EMRG) | ~want[0]) & ((st_reg[1] == ST_EMRG) | ~want[1]);
  wire [11:0] sp1       = setpt_reg[11:0];
  wire [11:0] sp2       = setpt_reg[23:12];

  // ----------------------------------------
  // Temperature staging
  // ----------------------------------------
  // hysteresis on falling edges
  always_comb begin
    stage_next = stage_reg;
    case (stage_reg)
      2'h0: if (tempIn >= sp1) stage_next = 2'h1;
      2'h1: begin
        if (tempIn >= sp2) stage_next = 2'h2;
        else if ({1'b0, tempIn} + {1'b0, hyst_reg} < {1'b0, sp1}) stage_next = 2'h0;
      end
      2'h2: if ({1'b0, tempIn} + {1'b0, hyst_reg} < {1'b0, sp2}) stage_next = 2'h1;
      default: stage_next = 2'h0;
    endcase
  end

  // ----------------------------------------
  // Per-fan sequencing
  // ----------------------------------------
  always_comb begin
    alarmSet    = 13'h0000;
    rotEvt      = 2'h0;
    failEvt     = 2'h0;
    stbyEvt     = 2'h0;
    flowOk_next = flowOk_reg;
    locked_next = cmdUnlock ? 2'h0 : locked_reg;
    for (int i = 0; i < 2; i++) begin
      st_next[i]  = st_reg[i];
      cnt_next[i] = cnt_reg[i];
      case (st_reg[i])
        ST_IDLE: begin
          cnt_next[i] = 8'h00;
          flowOk_next[i] = 1'b0;
          if (want[i] & emerg) st_next[i] = ST_EMRG;
          else if (want[i]) st_next[i] = ST_OPEN;
        end
        ST_OPEN: begin
          if (!want[i] || emerg) begin
            st_next[i] = ST_IDLE;
          end else if (&fanIn[i].damperOpen) begin
            st_next[i]  = ST_PROVE;
            cnt_next[i] = 8'h00;
          end else if (tick_reg) begin
            cnt_next[i] = cnt_reg[i] + 8'h01;
            if (cnt_reg[i] + 8'h01 >= dmpTo_reg) begin
              st_next[i]      = ST_IDLE;
              alarmSet[6 + i] = 1'b1;
              locked_next[i]  = 1'b1;
            end
          end
        end
        ST_PROVE, ST_RUN: begin
          if (fanIn[i].flowOk) flowOk_next[i] = 1'b1;
          if (!want[i]) begin
            st_next[i] = ST_IDLE;
            rotEvt[i]  = st_reg[i] == ST_RUN;
          end else if (emerg) begin
            st_next[i] = ST_EMRG;
          end else if (fanIn[i].fault | fanIn[i].trip) begin
            st_next[i]     = ST_IDLE;
            alarmSet[i]    = 1'b1;
            failEvt[i]     = 1'b1;
            stbyEvt[i]     = 1'b1;
            rotEvt[i]      = 1'b1;
            locked_next[i] = 1'b1;
          end else if (st_reg[i] == ST_PROVE && fanIn[i].running) begin
            st_next[i]  = ST_RUN;
            cnt_next[i] = 8'h00;
          end else if (tick_reg && !flowOk_reg[i]) begin
            cnt_next[i] = cnt_reg[i] + 8'h01;
            if (st_reg[i] == ST_PROVE && cnt_reg[i] + 8'h01 >= PROVE_TICKS) begin
              st_next[i]      = ST_IDLE;
              alarmSet[4 + i] = 1'b1;
              rotEvt[i]       = 1'b1;
              locked_next[i]  = 1'b1;
            end else if (st_reg[i] == ST_RUN && cnt_reg[i] + 8'h01 >= FLOW_TICKS) begin
              st_next[i]      = ST_IDLE;
              alarmSet[2 + i] = 1'b1;
              stbyEvt[i]      = 1'b1;
              rotEvt[i]       = 1'b1;
              locked_next[i]  = 1'b1;
            end
          end
        end
        ST_EMRG: begin
          if (!want[i] || !emerg) begin
            st_next[i] = ST_IDLE;
            rotEvt[i]  = 1'b1;
          end
          if (fanIn[i].fault | fanIn[i].trip) alarmSet[8 + i] = 1'b1;
        end
        default: st_next[i] = ST_IDLE;
      endcase
    end
    alarmSet[11] = stage_reg != 2'h0;
    alarmSet[12] = stage_reg == 2'h2;
    alarmSet[10] = (panelAct | wsAct) & tick_reg & (scenCnt_reg == SCEN_TICKS) & ~scenDone;
  end

  // ----------------------------------------
  // Tick and hours
  // ----------------------------------------
  // tick from system clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tickCnt_reg <= 27'h0000000;
      tick_reg    <= 1'b0;
    end else begin
      tick_reg    <= tickCnt_reg == 27'(TICK_CYCLES - 1);
      tickCnt_reg <= (tickCnt_reg == 27'(TICK_CYCLES - 1)) ? 27'h0000000 : tickCnt_reg + 27'h0000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        secCnt_reg[i] <= 12'h000;
        hours_reg[i]  <= 20'h00000;
      end
    end else if (tick_reg) begin
      for (int i = 0; i < 2; i++) begin
        if (fanIn[i].running) begin
          secCnt_reg[i] <= (secCnt_reg[i] == HOUR_TICKS - 12'h001) ? 12'h000 : secCnt_reg[i] + 12'h001;
          if (secCnt_reg[i] == HOUR_TICKS - 12'h001) hours_reg[i] <= hours_reg[i] + 20'h00001;
        end
      end
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg[0]  <= ST_IDLE;
      st_reg[1]  <= ST_IDLE;
      cnt_reg[0] <= 8'h00;
      cnt_reg[1] <= 8'h00;
      flowOk_reg <= 2'h0;
      locked_reg <= 2'h0;
      stage_reg  <= 2'h0;
      alarm_reg  <= 13'h0000;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      flowOk_reg <= flowOk_next;
      locked_reg <= locked_next;
      stage_reg  <= stage_next;
      alarm_reg  <= (alarm_reg & ~alarmClr) | alarmSet;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) duty_reg <= 1'b0;
    else if (|rotEvt) duty_reg <= rotEvt[0];
    else if (stage_reg != 2'h1 && stage_next == 2'h1) duty_reg <= lowHrs;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manRun_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wrCtrl && autoMode[i] && !pwdata[`FDS_CTRL_AUTO + i]) manRun_reg[i] <= st_reg[i] != ST_IDLE;
        else if (cmdStop[i] || stbyEvt[i]) manRun_reg[i] <= 1'b0;
        else if (cmdStart[i] || stbyEvt[1 - i]) manRun_reg[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locRun_reg <= 2'h0;
    end else if (localSel == LOC_REMOTE) begin
      locRun_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (localStopPb[i] || (stbyEvt[i] && !locEmerg)) locRun_reg[i] <= 1'b0;
        else if (localStartPb[i] || (stbyEvt[1 - i] && !locEmerg)) locRun_reg[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scenCnt_reg  <= 8'h00;
      scenCode_reg <= 2'h0;
    end else begin
      scenCode_reg <= scenCode;
      if (scenCode != scenCode_reg || !(panelAct | wsAct)) scenCnt_reg <= 8'h00;
      else if (tick_reg && scenCnt_reg != SCEN_TICKS) scenCnt_reg <= scenCnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg  <= `FDS_CTRL_RST;
      dmpTo_reg <= `FDS_DMP_TO_RST;
      setpt_reg <= `FDS_SETPT_RST;
      hyst_reg  <= `FDS_HYST_RST;
    end else begin
      if (wrCtrl) ctrl_reg <= pwdata[7:0];
      if (panelAct) ctrl_reg[7:4] <= 4'h0;
      if (accessWr && hitDmp) dmpTo_reg <= pwdata[7:0];
      if (accessWr && hitSet) setpt_reg <= pwdata[23:0];
      if (accessWr && hitHyst) hyst_reg <= pwdata[11:0];
    end
  end

  wire [31:0] statusWord = {14'h0000, locked_reg, maint, panelAct, locEmerg, emerg, duty_reg,
                            stage_reg, 2'h0, st_reg[1], st_reg[0]};
  wire [31:0] rdMux = hitCtrl  ? {24'h000000, ctrl_reg} :
                      hitDmp   ? {24'h000000, dmpTo_reg} :
                      hitSet   ? {8'h00, setpt_reg} :
                      hitHyst  ? {20'h00000, hyst_reg} :
                      hitStat  ? statusWord :
                      hitAlarm ? {19'h00000, alarm_reg} :
                      hitHrs0  ? {12'h000, hours_reg[0]} :
                      hitHrs1  ? {12'h000, hours_reg[1]} : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setupPh;
      pslverr_reg <= setupPh & ~addrHit;
      if (setupPh) prdata_reg <= pwrite ? 32'h00000000 : rdMux;
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fanOut_reg      <= '0;
      faultEvent_reg  <= 2'h0;
      alarmOut_reg    <= 1'b0;
      netScenario_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        fanOut_reg[i].start       <= st_next[i] inside {ST_PROVE, ST_RUN, ST_EMRG};
        fanOut_reg[i].damperOpen  <= st_next[i] != ST_IDLE;
        fanOut_reg[i].damperClose <= st_next[i] == ST_IDLE;
        fanOut_reg[i].reverse     <= (st_next[i] == ST_EMRG) & emRev[i];
      end
      faultEvent_reg  <= failEvt;
      alarmOut_reg    <= |alarm_reg[10:0];
      netScenario_reg <= panelAct ? panelScenarioPb : 2'h0;
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign fanOut      = fanOut_reg;
  assign faultEvent  = faultEvent_reg;
  assign alarmOut    = alarmOut_reg;
  assign netScenario = netScenario_reg;

endmodule

// ==== dv/fds_sequencer_sva.sv ====
// Port checker for the fan duty and standby sequencer
`timescale 1ns/1ps
module fds_sequencer_sva
  import fds_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Field and panel
  input wire fds_fan_in_type [1:0]  fanIn,
  input wire fds_local_sel_type     localSel,
  input wire logic                  panelScenarioSel,
  input wire logic [1:0]            panelScenarioPb,
  input wire fds_fan_out_type [1:0] fanOut,
  input wire logic [1:0]            faultEvent,
  input wire logic                  alarmOut,
  input wire logic [1:0]            netScenario
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic emg = (panelScenarioSel && panelScenarioPb != 2'h0) || localSel == LOC_EMERG;
  int flowCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flowCnt <= 0;
    end else if (!fanOut[0].start || fanIn[0].flowOk || emg) begin
      flowCnt <= 0;
    end else begin
      flowCnt <= flowCnt + 1;
    end
  end
  a_dmp_first: assert property ($rose(fanOut[0].start) && !emg && !$past(emg) |->
    $past(fanOut[0].damperOpen) && ($past(fanIn[0].damperOpen) == 2'h3 || $past(fanIn[0].damperOpen, 2) == 2'h3))
    else $error("start before damper open");
  a_maint_hold: assert property (fanIn[0].maint [*3] |-> !fanOut[0].start && !fanOut[0].damperOpen)
    else $error("maintenance fan driven");
  a_evt_cause: assert property ($rose(faultEvent[0]) |->
    $past(fanIn[0].fault || fanIn[0].trip) ##[0:2] alarmOut) else $error("fault event without cause");
  a_evt_pulse: assert property (faultEvent[0] |=> !faultEvent[0]) else $error("fault event too long");
  a_flow_limit: assert property (flowCnt <= 12 * TICK_CYCLES) else $error("flow not proven in time");
  a_emrg_together: assert property (emg && $past(emg) && $rose(fanOut[0].damperOpen) && !fanIn[0].maint
    |-> fanOut[0].start) else $error("emergency damper without fan");
  a_net_fwd: assert property ((panelScenarioSel && $stable(panelScenarioPb)) [*3]
    |-> netScenario == panelScenarioPb) else $error("scenario not forwarded");
  a_net_idle: assert property (!panelScenarioSel [*2] |-> netScenario == 2'h0)
    else $error("scenario forwarded while idle");
  a_stop_close: assert property ($fell(fanOut[0].damperOpen) |-> !fanOut[0].start && fanOut[0].damperClose)
    else $error("damper withdrawn with fan started");
endmodule
bind fds_sequencer fds_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clk(clk), .rst(rst), .fanIn(fanIn),
  .localSel(localSel), .panelScenarioSel(panelScenarioSel), .panelScenarioPb(panelScenarioPb), .fanOut(fanOut),
  .faultEvent(faultEvent), .alarmOut(alarmOut), .netScenario(netScenario));

// ==== dv/fds_field_model.sv ====
// Field equipment model: starters, dampers and sensors
`timescale 1ns/1ps
module fds_field_model
  import fds_pkg::*;
(
  input  wire logic                  clk,
  input  wire fds_fan_out_type [1:0] fanOut,
  // Fault knobs from the bench
  input  wire logic [1:0]            stuck,
  input  wire logic [1:0]            noFlow,
  input  wire logic [1:0]            faultIn,
  input  wire logic [1:0]            maintIn,
  output fds_fan_in_type [1:0]       fanIn
);
  logic [1:0] run = 2'h0;
  logic [1:0] flow = 2'h0;
  logic [1:0] dmp = 2'h0;
  always_ff @(posedge clk) begin
    run  <= {fanOut[1].start, fanOut[0].start} & ~faultIn;
    flow <= run & ~noFlow;
    dmp  <= {fanOut[1].damperOpen, fanOut[0].damperOpen};
  end
  // Stuck damper shows one section open only
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      fanIn[i] = '{run[i], flow[i], dmp[i] ? (stuck[i] ? 2'h1 : 2'h3) : 2'h0, faultIn[i], 1'b0, maintIn[i]};
    end
  end
endmodule

// ==== dv/fds_sequencer_tb.sv ====
// Self-checking bench for the fan duty and standby sequencer
`timescale 1ns/1ps
`include "fds_cfg.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t mismatch got %0h exp %0h", $time, a, b); end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge clk);
module fds_sequencer_tb
  import fds_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, scenSel = 1'b0, evtSeen = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, alarmOut;
  fds_fan_in_type [1:0] fanIn;
  fds_fan_out_type [1:0] fanOut;
  fds_local_sel_type localSel = LOC_REMOTE;
  logic [1:0] startPb = '0, scenPb = '0, stuck = '0, noFlow = '0, faultIn = '0, maintIn = '0;
  logic [1:0] faultEvent, netScenario;
  logic [11:0] tempIn = 12'h000;
  int err_count = 0, n_compared = 0;
  fds_sequencer #(.TICK_CYCLES(10)) dut (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fanIn(fanIn),
    .tempIn(tempIn), .localSel(localSel), .localStartPb(startPb), .localStopPb(2'h0),
    .panelScenarioSel(scenSel), .panelScenarioPb(scenPb), .fanOut(fanOut), .faultEvent(faultEvent),
    .alarmOut(alarmOut), .netScenario(netScenario));
  fds_field_model u_field (.clk(clk), .fanOut(fanOut), .stuck(stuck), .noFlow(noFlow), .faultIn(faultIn),
    .maintIn(maintIn), .fanIn(fanIn));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (faultEvent[0] === 1'b1) evtSeen <= 1'b1;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r & m, x)
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    logic [31:0] r;
    logic e;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`FDS_OFF_CTRL, 32'hFFFFFFFF, 32'(`FDS_CTRL_RST));
    rd(`FDS_OFF_DMPTO, 32'hFFFFFFFF, 32'(`FDS_DMP_TO_RST));
    rd(`FDS_OFF_SETPT, 32'hFFFFFFFF, 32'(`FDS_SETPT_RST));
    rd(`FDS_OFF_HYST, 32'hFFFFFFFF, 32'(`FDS_HYST_RST));
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK(e, 1'b1)
    `CHK(r, 32'h0)
    $display("test registers done");
    wr(`FDS_OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    `CHK(fanOut[0].damperOpen, 1'b0)
    wr(`FDS_OFF_CMD, 32'h1);
    `WAIT(fanOut[0].start === 1'b1, 40)
    repeat (8) @(posedge clk);
    rd(`FDS_OFF_STATUS, 32'h7, 32'h3);
    faultIn <= 2'b01;
    `WAIT(fanOut[1].start === 1'b1, 40)
    `CHK(fanOut[1].start, 1'b1)
    `CHK(fanOut[0].start, 1'b0)
    `CHK(evtSeen, 1'b1)
    rd(`FDS_OFF_ALARM, 32'h1, 32'h1);
    faultIn <= 2'b00;
    wr(`FDS_OFF_CMD, 32'h1C);
    wr(`FDS_OFF_ALARM, 32'h1FFF);
    $display("test failover done");
    noFlow <= 2'b01;
    wr(`FDS_OFF_CMD, 32'h1);
    `WAIT(fanOut[0].start === 1'b1, 40)
    repeat (80) @(posedge clk);
    `CHK(fanOut[0].start, 1'b1)
    `WAIT(fanOut[0].start === 1'b0, 60)
    rd(`FDS_OFF_ALARM, 32'h4, 32'h4);
    `WAIT(fanOut[1].start === 1'b1, 40)
    `CHK(fanOut[1].start, 1'b1)
    noFlow <= 2'b00;
    wr(`FDS_OFF_CMD, 32'h1C);
    wr(`FDS_OFF_ALARM, 32'h1FFF);
    $display("test flow done");
    wr(`FDS_OFF_DMPTO, 32'h3);
    stuck <= 2'b01;
    wr(`FDS_OFF_CMD, 32'h1);
    repeat (15) @(posedge clk);
    `CHK(fanOut[0].damperOpen, 1'b1)
    `WAIT(fanOut[0].damperClose === 1'b1, 40)
    `CHK(fanOut[0].start, 1'b0)
    rd(`FDS_OFF_ALARM, 32'h40, 32'h40);
    wr(`FDS_OFF_CMD, 32'h1C);
    wr(`FDS_OFF_ALARM, 32'h1FFF);
    $display("test damper done");
    maintIn <= 2'b01;
    wr(`FDS_OFF_CMD, 32'h1);
    repeat (10) @(posedge clk);
    `CHK(fanOut[0].damperOpen, 1'b0)
    // Panel selector to scenario position
    scenSel <= 1'b1;
    scenPb <= 2'h1;
    `WAIT(fanOut[1].start === 1'b1, 20)
    `CHK(fanOut[0].start, 1'b0)
    `CHK(netScenario, 2'h1)
    maintIn <= 2'b00;
    repeat (5) @(posedge clk);
    `CHK(fanOut[0].start & fanOut[0].damperOpen, 1'b1)
    scenPb <= 2'h2;
    `WAIT(fanOut[1].reverse === 1'b1, 1810)
    `CHK(fanOut[1].reverse, 1'b1)
    faultIn <= 2'b10;
    repeat (6) @(posedge clk);
    `CHK(fanOut[0].start & alarmOut, 1'b1)
    scenSel <= 1'b0;
    scenPb <= 2'h0;
    faultIn <= 2'b00;
    stuck <= 2'b00;
    wr(`FDS_OFF_CMD, 32'h1C);
    $display("test scenario done");
    startPb <= 2'b01;
    repeat (10) @(posedge clk);
    `CHK(fanOut[0].damperOpen, 1'b0)
    localSel <= LOC_NORMAL;
    `WAIT(fanOut[0].damperOpen === 1'b1, 20)
    `CHK(fanOut[0].damperOpen, 1'b1)
    $display("test local done");
    localSel <= LOC_REMOTE;
    tempIn <= 12'h1E0;
    repeat (4) @(posedge clk);
    rd(`FDS_OFF_ALARM, 32'h1800, 32'h1800);
    `CHK(fanOut[1].damperOpen, 1'b0)
    wr(`FDS_OFF_CTRL, 32'h3);
    `WAIT(fanOut[1].damperOpen === 1'b1, 20)
    `CHK(fanOut[0].damperOpen, 1'b1)
    tempIn <= 12'h1D8;
    repeat (8) @(posedge clk);
    `CHK(fanOut[1].damperOpen, 1'b1)
    tempIn <= 12'h000;
    `WAIT(fanOut[0].damperClose === 1'b1, 20)
    `CHK(fanOut[1].damperOpen, 1'b0)
    $display("test staging done");
    end_sim();
  end
endmodule
